/* File: rtl/pppsb_top.sv */
// parallel port pad steering and slave-mode byte buffers with status
// assumes avalon-mm master on ref_clk; host strobes synchronous to ref_clk
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
module pppsb_top
   import pppsb_pkg::*;
(
   input  wire logic                       ref_clk,       // 125 MHz clock
   input  wire logic                       reset,         // async, active high
   input  wire logic [pppsb_pkg::ADDR_W-1:0] avAddress,   // byte address
   input  wire logic                       avRead,        // read request
   input  wire logic                       avWrite,       // write request
   input  wire logic [31:0]                avWritedata,   // write data
   input  wire logic [3:0]                 avByteenable,  // byte lanes
   output logic [31:0]                     avReaddata,    // read data
   output logic                            avWaitrequest, // stall
   input  wire logic                       hostCs,        // host chip select
   input  wire logic                       hostRd,        // host read strobe
   input  wire logic                       hostWr,        // host write strobe
   input  wire logic [1:0]                 hostAddr,      // host low address
   input  wire logic [7:0]                 hostDataIn,    // host write data
   output logic [7:0]                      hostDataOut,   // host read data
   output logic                            hostDataOe,    // data pad drive
   output logic                            addr14PadPort, // pad 14 to port
   output logic                            addr14IsCs,    // pad 14 as cs
   output logic [pppsb_pkg::PEN_MID_W-1:0] midPadPort,    // pads 2..10 to port
   output logic [pppsb_pkg::PEN_LOW_W-1:0] lowPadPort,    // pads 0..1 to port
   output logic                            lowPadIsLatch, // pads 0..1 as strobes
   output logic                            irq            // level interrupt
);
   import pppsb_pkg::*;

   // ==========================================
   // registers
   logic [31:0]       portPinEnable;
   logic [31:0]       ctrlReg;
   logic [INT_W-1:0]  intStat;
   logic [INT_W-1:0]  intMask;
   logic [INT_W-1:0]  rdSnap;
   logic [7:0]        inBuf [NBUF];
   logic [7:0]        outBuf [NBUF];
   logic [NBUF-1:0]   inFull;
   logic [NBUF-1:0]   outEmpty;
   logic              inOvf;
   logic              outUnf;
   logic [1:0]        rdPtr;
   logic [1:0]        wrPtr;
   logic              hostRdPrev;
   logic              hostWrPrev;

   // ==========================================
   // bus decode
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] ofs);
      return a[ADDR_W-1:2] == ofs[5:2];
   endfunction

   wire       req      = avRead | avWrite;
   wire       accept   = req & ~avWaitrequest;
   wire       wrAcc    = avWrite & accept;
   wire       rdAcc    = avRead & accept;
   wire       selBuf   = avAddress[5:4] == BUF_PAGE;
   wire [1:0] swIdx    = avAddress[3:2];
   wire       swRdBuf  = rdAcc & selBuf;
   wire       swWrBuf  = wrAcc & selBuf & avByteenable[0];
   wire       rdIntSt  = rdAcc & hit(avAddress, OFS_INT_STAT);
   wire [31:0] beMask  = {{8{avByteenable[3]}}, {8{avByteenable[2]}},
                          {8{avByteenable[1]}}, {8{avByteenable[0]}}};

   // ==========================================
   // control fields
   pppsb_mode_t portMode;
   assign portMode = pppsb_mode_t'(ctrlReg[CT_MODE +: 2]);
   wire [1:0] incMode = ctrlReg[CT_INCM +: 2];
   wire [1:0] irqMode = ctrlReg[CT_IRQM +: 2];
   wire [1:0] csFunc  = ctrlReg[CT_CSF +: 2];
   wire [1:0] adMux   = ctrlReg[CT_ADRMUX +: 2];

   // ==========================================
   // host side
   // mode decode
   wire slaveMode = (portMode == PPPSB_LEGACY) | (portMode == PPPSB_ENH);
   wire autoInc   = (portMode == PPPSB_LEGACY) & (incMode == INCM_AUTO);
   // a strobe held high counts once; the host must drop it between accesses
   // master modes leave the buffers alone
   wire hRdEvt = slaveMode & hostCs & hostRd & ~hostRdPrev;
   wire hWrEvt = slaveMode & hostCs & hostWr & ~hostWrPrev;
   // enhanced picks by address, legacy by pointer
   wire [1:0] hRdSel = (portMode == PPPSB_ENH) ? hostAddr : (autoInc ? rdPtr : 2'h0);
   wire [1:0] hWrSel = (portMode == PPPSB_ENH) ? hostAddr : (autoInc ? wrPtr : 2'h0);
   wire ovfEvt = hWrEvt & inFull[hWrSel];
   wire unfEvt = hRdEvt & outEmpty[hRdSel];
   wire errEvt = ovfEvt | unfEvt;
   wire accEvt = (irqMode == IRQM_END) ? (hRdEvt | hWrEvt) :
                 (irqMode == IRQM_BUF3) ? ((hRdEvt & (hRdSel == LAST_BUF)) |
                                           (hWrEvt & (hWrSel == LAST_BUF))) : 1'b0;
   wire [INT_W-1:0] intEvt = {accEvt, errEvt};

   // ==========================================
   // status read view
   // all input full; all output empty; gaps zero
   wire [31:0] statusView = {16'h0000, &inFull, inOvf, 2'h0, inFull,
                             &outEmpty, outUnf, 2'h0, outEmpty};
   wire [31:0] rdMux =
      hit(avAddress, OFS_PIN_EN)   ? portPinEnable :
      hit(avAddress, OFS_STATUS)   ? statusView :
      hit(avAddress, OFS_CTRL)     ? ctrlReg :
      hit(avAddress, OFS_INT_STAT) ? {30'h0, intStat} :
      hit(avAddress, OFS_INT_MASK) ? {30'h0, intMask} :
      selBuf                       ? {24'h0, inBuf[swIdx]} : 32'h0;

   // ==========================================
   // next values
   // reserved pin enable bits never stored
   wire [31:0] next_pinEn = (portPinEnable & ~(beMask & PEN_WMASK)) |
                            (avWritedata & beMask & PEN_WMASK);
   wire [31:0] next_ctrl  = (ctrlReg & ~(beMask & CTRL_WMASK)) |
                            (avWritedata & beMask & CTRL_WMASK);
   wire wrStat = wrAcc & hit(avAddress, OFS_STATUS) & avByteenable[1];
   wire wrStatLo = wrAcc & hit(avAddress, OFS_STATUS) & avByteenable[0];
   // software clears by writing zero, set wins
   wire next_inOvf = ovfEvt | (inOvf & ~(wrStat & ~avWritedata[ST_INPUT_OVERFLOW_FLAG]));
   // software clears by writing zero, set wins
   wire next_outUnf = unfEvt | (outUnf & ~(wrStatLo & ~avWritedata[ST_OUTPUT_UNDERFLOW_FLAG]));
   // only bits actually seen by the read are cleared
   wire [INT_W-1:0] next_intStat = intEvt | (intStat & ~(rdIntSt ? rdSnap : '0));

   // ==========================================
   // bus slave
   // one wait cycle, then a one-cycle accept
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         avWaitrequest <= 1'b1;
         avReaddata    <= 32'h0;
         rdSnap        <= '0;
      end else begin
         avWaitrequest <= ~(req & avWaitrequest);
         if (avRead & avWaitrequest) begin
            avReaddata <= rdMux;
            rdSnap     <= hit(avAddress, OFS_INT_STAT) ? intStat : '0;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         portPinEnable <= 32'h0;
         ctrlReg       <= 32'h0;
         intMask       <= '0;
      end else if (wrAcc) begin
         if (hit(avAddress, OFS_PIN_EN))
            portPinEnable <= next_pinEn;
         if (hit(avAddress, OFS_CTRL))
            ctrlReg <= next_ctrl;
         if (hit(avAddress, OFS_INT_MASK) & avByteenable[0])
            intMask <= avWritedata[INT_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         inOvf   <= 1'b0;
         outUnf  <= 1'b0;
         intStat <= '0;
         irq     <= 1'b0;
      end else begin
         inOvf   <= next_inOvf;
         outUnf  <= next_outUnf;
         intStat <= next_intStat;
         // trails a mask write by one cycle, which keeps irq a plain flop
         irq     <= |(next_intStat & intMask);
      end
   end

   // ==========================================
   // per-buffer storage and flags
   for (genvar i = 0; i < NBUF; i++) begin : g_buf
      wire hW = hWrEvt & (hWrSel == 2'(i));
      wire hR = hRdEvt & (hRdSel == 2'(i));
      wire sR = swRdBuf & (swIdx == 2'(i));
      wire sW = swWrBuf & (swIdx == 2'(i));
      always_ff @(posedge ref_clk or posedge reset) begin
         if (reset) begin
            inFull[i]   <= 1'b0;
            outEmpty[i] <= 1'b1;
            inBuf[i]    <= 8'h00;
            outBuf[i]   <= 8'h00;
         end else begin
            // host write sets, software read clears
            // a full buffer keeps its unread byte
            if (hW & ~inFull[i])
               inBuf[i] <= hostDataIn;
            inFull[i] <= hW | (inFull[i] & ~sR);
            // software write clears, host read sets
            if (sW)
               outBuf[i] <= avWritedata[7:0];
            // a host read racing a software write leaves it empty: set wins
            outEmpty[i] <= hR | (outEmpty[i] & ~sW);
         end
      end
   end

   // ==========================================
   // host strobe edges and pointers
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         hostRdPrev  <= 1'b0;
         hostWrPrev  <= 1'b0;
         rdPtr       <= 2'h0;
         wrPtr       <= 2'h0;
         hostDataOut <= 8'h00;
         hostDataOe  <= 1'b0;
      end else begin
         hostRdPrev <= hostRd;
         hostWrPrev <= hostWr;
         // pointers wrap through the four buffers
         // parked at zero while off, so enabling always starts at buffer 0
         if (!autoInc) begin
            rdPtr <= 2'h0;
            wrPtr <= 2'h0;
         end else begin
            if (hRdEvt)
               rdPtr <= rdPtr + 2'h1;
            if (hWrEvt)
               wrPtr <= wrPtr + 2'h1;
         end
         if (hRdEvt)
            hostDataOut <= outBuf[hRdSel];
         hostDataOe <= slaveMode & hostCs & hostRd;
      end
   end

   // ==========================================
   // pad steering
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         addr14PadPort <= 1'b0;
         addr14IsCs    <= 1'b0;
         midPadPort    <= '0;
         lowPadPort    <= '0;
         lowPadIsLatch <= 1'b0;
      end else begin
         addr14PadPort <= portPinEnable[PEN_A14];
         // chip select when field says so
         addr14IsCs    <= portPinEnable[PEN_A14] & (csFunc == CSF_CS1);
         midPadPort    <= portPinEnable[PEN_MID_LSB +: PEN_MID_W];
         lowPadPort    <= portPinEnable[0 +: PEN_LOW_W];
         // strobes when pad 0 or pad 1 is enabled and address and data share the bus
         lowPadIsLatch <= (|portPinEnable[0 +: PEN_LOW_W]) & (adMux != ADRMUX_NONE);
      end
   end

   // ==========================================
   // checks
   a_wait_one: assert property (@(posedge ref_clk) disable iff (reset) // bus
      req & avWaitrequest |=> !avWaitrequest ##1 avWaitrequest)
      else $error("waitrequest not one cycle low");
   a_pen_rsvd: assert property (@(posedge ref_clk) disable iff (reset)
      (portPinEnable & ~PEN_WMASK) == 32'h0)
      else $error("reserved pin enable bit set");
   a_stat_rsvd: assert property (@(posedge ref_clk) disable iff (reset)
      avRead & !avWaitrequest & $past(hit(avAddress, OFS_STATUS))
      |-> (avReaddata & 32'hFFFF_3030) == 32'h0)
      else $error("reserved status bit read one");
   a_ovf_set: assert property (@(posedge ref_clk) disable iff (reset)
      ovfEvt |=> inOvf)
      else $error("overflow not flagged");
   a_unf_set: assert property (@(posedge ref_clk) disable iff (reset)
      unfEvt |=> outUnf)
      else $error("underflow not flagged");
   a_err_int: assert property (@(posedge ref_clk) disable iff (reset)
      errEvt & intMask[INT_ERR] |=> irq)
      else $error("error interrupt missing");
   a_ibf_all: assert property (@(posedge ref_clk) disable iff (reset)
      statusView[ST_IBF] == (inFull == 4'hF))
      else $error("all-full flag wrong");
   a_obe_all: assert property (@(posedge ref_clk) disable iff (reset)
      statusView[ST_OBE] == (outEmpty == 4'hF))
      else $error("all-empty flag wrong");
   a_full_set: assert property (@(posedge ref_clk) disable iff (reset)
      hWrEvt |=> inFull[$past(hWrSel)])
      else $error("input full not set");
   a_master_idle: assert property (@(posedge ref_clk) disable iff (reset)
      !slaveMode & !wrAcc & !rdAcc |=> $stable(inFull) && $stable(inOvf))
      else $error("buffer moved in master mode");
   a_pad14_cs: assert property (@(posedge ref_clk) disable iff (reset)
      addr14IsCs |-> addr14PadPort)
      else $error("chip select on disabled pad");

   // ==========================================
   // checks: pads, flags, host side and bus
   a_pad14_en: assert property (@(posedge ref_clk) disable iff (reset)
      addr14PadPort == $past(portPinEnable[PEN_A14]))
      else $error("pad 14 enable not followed");
   a_mid_pads: assert property (@(posedge ref_clk) disable iff (reset)
      midPadPort == $past(portPinEnable[PEN_MID_LSB +: PEN_MID_W]))
      else $error("mid pad enables not followed");
   a_low_pads: assert property (@(posedge ref_clk) disable iff (reset)
      lowPadPort == $past(portPinEnable[0 +: PEN_LOW_W]))
      else $error("low pad enables not followed");
   a_cs_field: assert property (@(posedge ref_clk) disable iff (reset)
      addr14IsCs |-> $past(csFunc) == CSF_CS1)
      else $error("chip select without field");
   a_latch_mode: assert property (@(posedge ref_clk) disable iff (reset)
      lowPadIsLatch |-> $past(adMux) != ADRMUX_NONE)
      else $error("latch strobes without multiplex");
   a_full_clr: assert property (@(posedge ref_clk) disable iff (reset)
      swRdBuf & !hWrEvt |=> !inFull[$past(swIdx)])
      else $error("input full not cleared");
   a_ovf_hold: assert property (@(posedge ref_clk) disable iff (reset)
      inOvf & !wrStat |=> inOvf)
      else $error("overflow flag dropped");
   a_drop_full: assert property (@(posedge ref_clk) disable iff (reset)
      hWrEvt & inFull[hWrSel] |=> inBuf[$past(hWrSel)] == $past(inBuf[hWrSel]))
      else $error("full buffer overwritten");
   a_empty_set: assert property (@(posedge ref_clk) disable iff (reset)
      hRdEvt |=> outEmpty[$past(hRdSel)])
      else $error("output empty not set");
   a_empty_clr: assert property (@(posedge ref_clk) disable iff (reset)
      swWrBuf & !hRdEvt |=> !outEmpty[$past(swIdx)])
      else $error("output empty not cleared");
   a_unf_hold: assert property (@(posedge ref_clk) disable iff (reset)
      outUnf & !wrStatLo |=> outUnf)
      else $error("underflow flag dropped");
   a_err_any: assert property (@(posedge ref_clk) disable iff (reset)
      errEvt |=> intStat[INT_ERR])
      else $error("error status not set");
   a_irq_level: assert property (@(posedge ref_clk) disable iff (reset)
      irq == |(intStat & $past(intMask)))
      else $error("irq level wrong");
   a_oe_slave: assert property (@(posedge ref_clk) disable iff (reset)
      hostDataOe |-> $past(slaveMode))
      else $error("data pads driven in master mode");
   a_auto_step: assert property (@(posedge ref_clk) disable iff (reset)
      hWrEvt & autoInc |=> wrPtr == $past(wrPtr) + 2'h1)
      else $error("write pointer did not step");
   a_ptr_park: assert property (@(posedge ref_clk) disable iff (reset)
      !autoInc |=> (wrPtr == 2'h0) && (rdPtr == 2'h0))
      else $error("pointers not parked");
   a_acc_buf3: assert property (@(posedge ref_clk) disable iff (reset)
      hWrEvt & (irqMode == IRQM_BUF3) & (hWrSel == LAST_BUF) |=> intStat[INT_ACC])
      else $error("buffer 3 access interrupt missing");
   a_enh_select: assert property (@(posedge ref_clk) disable iff (reset)
      hWrEvt & (portMode == PPPSB_ENH) & !inFull[hostAddr] |=> inBuf[$past(hostAddr)] == $past(hostDataIn))
      else $error("enhanced write landed wrong");
   a_wait_idle: assert property (@(posedge ref_clk) disable iff (reset) // bus
      !req |=> avWaitrequest)
      else $error("waitrequest low while idle");
   a_rdata_take: assert property (@(posedge ref_clk) disable iff (reset) // bus
      avRead & avWaitrequest |=> avReaddata == $past(rdMux))
      else $error("read data not captured");
endmodule

/* File: pkg/pppsb_pkg.sv */
// constants, field layout and modes of the parallel port pins and slave buffers
// assumes a 32-bit avalon-mm slave port with byte addresses
package pppsb_pkg;
   localparam int ADDR_W = 6;
   localparam int NBUF   = 4;
   // ==========================================
   // register byte offsets
   localparam logic [5:0] OFS_PIN_EN   = 6'h00;
   localparam logic [5:0] OFS_STATUS   = 6'h04;
   localparam logic [5:0] OFS_CTRL     = 6'h08;
   localparam logic [5:0] OFS_INT_STAT = 6'h0C;
   localparam logic [5:0] OFS_INT_MASK = 6'h10;
   localparam logic [1:0] BUF_PAGE     = 2'h2;
   // ==========================================
   // pin enable fields
   localparam int PEN_A14     = 14;
   localparam int PEN_MID_LSB = 2;
   localparam int PEN_MID_W   = 9;
   localparam int PEN_LOW_W   = 2;
   localparam logic [31:0] PEN_WMASK = 32'h0000_47FF;
   // ==========================================
   // status fields
   localparam int ST_IBF  = 15;
   localparam int ST_INPUT_OVERFLOW_FLAG = 14;
   localparam int ST_INPUT_BYTE_FULL_FLAGS = 8;
   localparam int ST_OBE  = 7;
   localparam int ST_OUTPUT_UNDERFLOW_FLAG = 6;
   localparam int ST_OUTPUT_BYTE_EMPTY_FLAGS = 0;
   // ==========================================
   // control fields
   localparam int CT_MODE   = 0;
   localparam int CT_INCM   = 2;
   localparam int CT_IRQM   = 4;
   localparam int CT_CSF    = 6;
   localparam int CT_ADRMUX = 8;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_03FF;
   localparam logic [1:0] INCM_AUTO   = 2'h3;
   localparam logic [1:0] IRQM_END    = 2'h1;
   localparam logic [1:0] IRQM_BUF3   = 2'h2;
   localparam logic [1:0] CSF_CS1     = 2'h2;
   localparam logic [1:0] ADRMUX_NONE = 2'h0;
   localparam logic [1:0] LAST_BUF    = 2'h3;
   // ==========================================
   // interrupt status bits
   localparam int INT_ERR = 0;
   localparam int INT_ACC = 1;
   localparam int INT_W   = 2;
   typedef enum logic [1:0] {
      PPPSB_LEGACY = 2'b00,
      PPPSB_ENH    = 2'b01,
      PPPSB_MST2   = 2'b10,
      PPPSB_MST1   = 2'b11
   } pppsb_mode_t;
endpackage

/* File: sim/pppsb_host_model.sv */
// external host model: drives the parallel slave strobes and byte data
// assumes host strobes are synchronous to ref_clk
module pppsb_host_model (
   input  wire logic       ref_clk,     // system clock
   output logic            hostCs,      // chip select
   output logic            hostRd,      // read strobe
   output logic            hostWr,      // write strobe
   output logic [1:0]      hostAddr,    // low address
   output logic [7:0]      hostDataIn,  // data to device
   input  wire logic [7:0] hostDataOut  // data from device
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      hostCs = 1'b0;
      hostRd = 1'b0;
      hostWr = 1'b0;
      hostAddr = 2'h0;
      hostDataIn = 8'hA5;
   end
   // ==========================================
   // one strobe, held three edges, then released for one
   task automatic access(input logic wr, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge ref_clk);
      hostCs <= 1'b1;
      hostRd <= !wr;
      hostWr <= wr;
      hostAddr <= a;
      hostDataIn <= d;
      repeat (3) @(posedge ref_clk);
      q = hostDataOut;
      hostCs <= 1'b0;
      hostRd <= 1'b0;
      hostWr <= 1'b0;
      // released bus must not keep the last byte
      hostDataIn <= ~d;
      @(posedge ref_clk);
   endtask
endmodule

/* File: sim/pppsb_top_tb.sv */
// self-checking bench: avalon-mm register tasks plus host strobe model
// assumes the designer's one-wait-cycle avalon slave and 125 MHz clock
module pppsb_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pppsb_pkg::*;
   localparam logic [31:0] ST_RST = (32'hF << ST_OUTPUT_BYTE_EMPTY_FLAGS) | (32'h1 << ST_OBE);
   logic        ref_clk, reset, avRead, avWrite, avWaitrequest, hostCs, hostRd, hostWr, hostDataOe;
   logic        addr14PadPort, addr14IsCs, lowPadIsLatch, irq;
   logic [5:0]  avAddress;
   logic [31:0] avWritedata, avReaddata, exp;
   logic [3:0]  avByteenable;
   logic [1:0]  hostAddr, lowPadPort;
   logic [7:0]  hostDataIn, hostDataOut, hq;
   logic [8:0]  midPadPort;
   int          errCount, numChecks;
   pppsb_top dut_u (.ref_clk(ref_clk), .reset(reset), .avAddress(avAddress), .avRead(avRead),
      .avWrite(avWrite), .avWritedata(avWritedata), .avByteenable(avByteenable), .avReaddata(avReaddata),
      .avWaitrequest(avWaitrequest), .hostCs(hostCs), .hostRd(hostRd), .hostWr(hostWr),
      .hostAddr(hostAddr), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
      .addr14PadPort(addr14PadPort), .addr14IsCs(addr14IsCs), .midPadPort(midPadPort),
      .lowPadPort(lowPadPort), .lowPadIsLatch(lowPadIsLatch), .irq(irq));
   pppsb_host_model host_u (.ref_clk(ref_clk), .hostCs(hostCs), .hostRd(hostRd), .hostWr(hostWr),
      .hostAddr(hostAddr), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // ==========================================
   // checking and verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      numChecks++;
      if (got !== want) begin
         errCount++;
         $display("Error at %0t ns: got %h expected %h", $time, got, want);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ==========================================
   // avalon-mm master: hold request until waitrequest sampled low
   task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      avWrite <= wr;
      avRead <= !wr;
      avAddress <= a;
      avWritedata <= d;
      do begin
         @(posedge ref_clk);
      end while (avWaitrequest !== 1'b0);
      q = avReaddata;
      avWrite <= 1'b0;
      avRead <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      av(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] want);
      logic [31:0] q;
      av(1'b0, a, 32'h0, q);
      chk(q, want);
   endtask
   function automatic logic [5:0] bufAddr(input int n);
      return {BUF_PAGE, n[1:0], 2'h0};
   endfunction
   function automatic logic [31:0] pads();
      return {18'h0, addr14PadPort, addr14IsCs, midPadPort, lowPadPort, lowPadIsLatch};
   endfunction
   // ==========================================
   // main sequence
   initial begin
      errCount = 0;
      numChecks = 0;
      reset = 1'b1;
      avRead = 1'b0;
      avWrite = 1'b0;
      avAddress = 6'h00;
      avWritedata = 32'h0;
      avByteenable = 4'hF;
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      rd(OFS_STATUS, ST_RST);
      rd(OFS_PIN_EN, 32'h0);
      rd(6'h3C, 32'h0);
      wr(OFS_PIN_EN, 32'hFFFF_FFFF);
      rd(OFS_PIN_EN, PEN_WMASK);
      wr(OFS_CTRL, ({30'h0, CSF_CS1} << CT_CSF) | (32'h1 << CT_ADRMUX));
      repeat (2) @(posedge ref_clk);
      chk(pads(), 32'h0000_3FFF);
      wr(OFS_PIN_EN, 32'h0000_4005);
      wr(OFS_CTRL, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk(pads(), 32'h0000_200A);
      // enhanced slave, host fills all four input buffers
      wr(OFS_INT_MASK, 32'h1 << INT_ERR);
      wr(OFS_CTRL, {30'h0, PPPSB_ENH} | ({30'h0, IRQM_BUF3} << CT_IRQM));
      exp = ST_RST;
      for (int n = 0; n < NBUF; n++) begin
         host_u.access(1'b1, n[1:0], 8'h10 + n[7:0], hq);
         exp = exp | (32'h1 << (ST_INPUT_BYTE_FULL_FLAGS + n)) | ((n == 3) ? (32'h1 << ST_IBF) : 32'h0);
         rd(OFS_STATUS, exp);
      end
      chk({31'h0, irq}, 32'h0);
      host_u.access(1'b1, 2'h2, 8'hEE, hq);
      rd(OFS_STATUS, exp | (32'h1 << ST_INPUT_OVERFLOW_FLAG));
      chk({31'h0, irq}, 32'h1);
      rd(OFS_INT_STAT, 32'h3);
      @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_CTRL, {30'h0, PPPSB_ENH});
      for (int n = 0; n < NBUF; n++) begin
         rd(bufAddr(n), 32'h10 + n);
      end
      rd(OFS_STATUS, ST_RST | (32'h1 << ST_INPUT_OVERFLOW_FLAG));
      wr(OFS_STATUS, 32'h0);
      rd(OFS_STATUS, ST_RST);
      // output buffers: software fills, host drains, then underflows
      for (int n = 0; n < NBUF; n++) begin
         wr(bufAddr(n), 32'h30 + n);
      end
      rd(OFS_STATUS, 32'h0);
      for (int n = 0; n < NBUF; n++) begin
         fork
            host_u.access(1'b0, n[1:0], 8'h00, hq);
            begin
               repeat (3) @(posedge ref_clk);
               chk({31'h0, hostDataOe}, 32'h1);
            end
         join
         chk({24'h0, hq}, 32'h30 + n);
      end
      rd(OFS_STATUS, ST_RST);
      host_u.access(1'b0, 2'h0, 8'h00, hq);
      rd(OFS_STATUS, ST_RST | (32'h1 << ST_OUTPUT_UNDERFLOW_FLAG));
      chk({31'h0, irq}, 32'h1);
      rd(OFS_INT_STAT, 32'h1 << INT_ERR);
      wr(OFS_STATUS, 32'h0);
      rd(OFS_STATUS, ST_RST);
      // master mode ignores host strobes
      wr(OFS_CTRL, {30'h0, PPPSB_MST2});
      host_u.access(1'b1, 2'h0, 8'h55, hq);
      rd(OFS_STATUS, ST_RST);
      wr(OFS_CTRL, {30'h0, PPPSB_MST1});
      host_u.access(1'b0, 2'h0, 8'h00, hq);
      rd(OFS_STATUS, ST_RST);
      // basic slave with auto increment
      wr(OFS_CTRL, ({30'h0, INCM_AUTO} << CT_INCM) | ({30'h0, IRQM_END} << CT_IRQM));
      host_u.access(1'b1, 2'h0, 8'h01, hq);
      host_u.access(1'b1, 2'h0, 8'h02, hq);
      rd(OFS_STATUS, ST_RST | (32'h3 << ST_INPUT_BYTE_FULL_FLAGS));
      rd(bufAddr(1), 32'h02);
      rd(OFS_INT_STAT, 32'h1 << INT_ACC);
      give_verdict();
   end
   // ==========================================
   // watchdog: the sequence needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      errCount++;
      $display("Error at %0t ns: got %h expected %h", $time, 1'b0, 1'b1);
      give_verdict();
   end
endmodule
